// [verilog/dio_pkg.sv]
package dio_pkg;
  // clock rate and qualification times
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TRIG_MIN_US = 10_000;  // 0.01 s
  localparam int unsigned SLOW_MIN_US = 100_000; // 0.1 s
  localparam int unsigned TRIG_MIN_CYC = (CLK_HZ / 1_000_000) * TRIG_MIN_US;
  localparam int unsigned SLOW_MIN_CYC = (CLK_HZ / 1_000_000) * SLOW_MIN_US;
  // program number range, held as zero-based code 0..15
  localparam int unsigned PROG_NUM = 16;
  localparam logic [3:0] PROG_RST = 4'h0;
  localparam logic [3:0] PROG_LAST = 4'hf;
  // default dispense cycle length in clock cycles
  localparam int unsigned DISP_CYC = 50_000_000;
  localparam int unsigned CNT_W = 32;
  // dispenser state
  typedef enum logic [1:0] {
    DIO_IDLE,
    DIO_DISP,
    DIO_ALARM,
    DIO_HALT
  } dio_state_t;
endpackage : dio_pkg

// [verilog/dio_if.sv]
`timescale 1ns/1ps
interface dio_if;
  logic voltage_trigger;
  logic contact_trigger;
  logic prog_step;
  logic estop;
  logic alarm_clear;
  logic alarm;
  logic eoc_b;
  modport device (
    input voltage_trigger, contact_trigger, prog_step, estop, alarm_clear,
    output alarm, eoc_b
  );
  modport ctrl (
    output voltage_trigger, contact_trigger, prog_step, estop, alarm_clear,
    input alarm, eoc_b
  );
endinterface : dio_if

// [verilog/dio_device.sv]
// Summary of operation
// - voltage trigger held 0.01 s starts cycle
// - held trigger never restarts; needs release first
// - contact trigger behaves like voltage trigger
// - each qualified step rising edge adds one program
// - program wraps from sixteen back to one
// - estop held 0.1 s enters halt mode
// - halt stops regulation, raises alarm, shows red
// - halt stays until estop released and touch or clear toggled
// - clear held 0.1 s clears alarm or halt
// - alarm output high throughout any alarm state
// - alarms block all cycle starts, show red
// - general alarm latches until touch or clear
// - end-of-cycle output low while dispensing
`timescale 1ns/1ps
module dio_device
  import dio_pkg::*;
#(
  parameter int unsigned TRIG_CYC = dio_pkg::TRIG_MIN_CYC,
  parameter int unsigned SLOW_CYC = dio_pkg::SLOW_MIN_CYC,
  parameter int unsigned DISP_LEN = dio_pkg::DISP_CYC
) (
  input wire logic clk_in,               // system clock
  input wire logic rst_b_in,             // async reset, low
  dio_if.device io,                      // discrete i/o port
  input wire logic touch_in,             // display touch pulse
  input wire logic alarm_req_in,         // general alarm event
  output logic regulate_out,             // pressure regulation on
  output logic warn_out,                 // red warning shown
  output logic dispensing_out,           // dispense cycle active
  output logic [3:0] prog_out            // active program minus one
);
  import dio_pkg::*;

  localparam int NIN = 5;
  localparam int unsigned LIM_ARR [NIN] =
    '{TRIG_CYC, TRIG_CYC, SLOW_CYC, SLOW_CYC, SLOW_CYC};

  // raw inputs: 0 volt, 1 contact, 2 step, 3 estop, 4 clear
  wire [NIN-1:0] raw_in;
  assign raw_in = {io.alarm_clear, io.estop, io.prog_step,
                   io.contact_trigger, io.voltage_trigger};

  logic [NIN-1:0] sync1_r;
  logic [NIN-1:0] sync2_r;
  logic [NIN-1:0] qual_r;
  logic [NIN-1:0] qual_d_r;

  // synchroniser and width qualifier per input
  // only the second flop feeds the qualifier, so a metastable first
  // stage never reaches the counters; a pulse shorter than the limit
  // restarts the count and is dropped, which filters contact bounce
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_in
      logic [CNT_W-1:0] cnt_r;
      always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          cnt_r <= '0;
          qual_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= raw_in[gi];
          sync2_r[gi] <= sync1_r[gi];
          if (sync2_r[gi] == qual_r[gi]) begin
            cnt_r <= '0;
          end else if (cnt_r >= CNT_W'(LIM_ARR[gi] - 1)) begin
            cnt_r <= '0;
            qual_r[gi] <= sync2_r[gi];
          end else begin
            cnt_r <= cnt_r + CNT_W'(1);
          end
        end
      end
    end
  endgenerate

  // edge detection on qualified levels
  wire [NIN-1:0] rise_w;
  wire [NIN-1:0] fall_w;
  assign rise_w = qual_r & ~qual_d_r;
  assign fall_w = ~qual_r & qual_d_r;

  // start only on fresh rising edge of either trigger
  wire start_w;
  assign start_w = rise_w[0] | rise_w[1];
  wire step_w;
  assign step_w = rise_w[2];
  wire halt_w;
  assign halt_w = qual_r[3];
  // clear on any change of qualified clear level, or a touch
  wire clr_w;
  assign clr_w = rise_w[4] | fall_w[4] | touch_in;

  dio_state_t state_r;
  dio_state_t state_nxt;
  logic [CNT_W-1:0] disp_cnt_r;
  logic [CNT_W-1:0] disp_cnt_nxt;
  logic [3:0] prog_r;
  wire disp_done_w;
  assign disp_done_w = disp_cnt_r >= CNT_W'(DISP_LEN - 1);

  // next program number, wrapping the last program back to the first
  wire [3:0] prog_inc_w;
  assign prog_inc_w = (prog_r == PROG_LAST) ? PROG_RST : prog_r + 4'h1;
  wire [3:0] prog_nxt;
  assign prog_nxt = step_w ? prog_inc_w : prog_r;

  // output levels decoded from the next state
  // regulation stops only in halt, a general alarm keeps pressure
  wire regulate_w;
  assign regulate_w = state_nxt != DIO_HALT;
  // end-of-cycle feedback follows the dispense state alone
  wire disp_st_w;
  assign disp_st_w = state_nxt == DIO_DISP;

  // the state machine sees the triggers only as qualified edges; an edge that comes
  // while busy or alarmed is lost, never queued for later

  // next state; halt outranks alarm, alarm outranks dispense
  always_comb begin
    state_nxt = state_r;
    disp_cnt_nxt = disp_cnt_r;
    unique case (state_r)
      DIO_IDLE: begin
        disp_cnt_nxt = '0;
        if (halt_w) begin
          state_nxt = DIO_HALT;
        end else if (alarm_req_in) begin
          state_nxt = DIO_ALARM;
        end else if (start_w) begin
          state_nxt = DIO_DISP;
        end
      end
      DIO_DISP: begin
        disp_cnt_nxt = disp_cnt_r + CNT_W'(1);
        if (halt_w) begin
          state_nxt = DIO_HALT;
        end else if (alarm_req_in) begin
          state_nxt = DIO_ALARM;
        end else if (disp_done_w) begin
          state_nxt = DIO_IDLE;
        end
      end
      DIO_ALARM: begin
        disp_cnt_nxt = '0;
        // new event in clear cycle keeps the alarm latched
        if (halt_w) begin
          state_nxt = DIO_HALT;
        end else if (clr_w && !alarm_req_in) begin
          state_nxt = DIO_IDLE;
        end
      end
      DIO_HALT: begin
        disp_cnt_nxt = '0;
        // held estop keeps the device halted
        if (clr_w && !halt_w) begin
          state_nxt = DIO_IDLE;
        end
      end
    endcase
  end

  // state, cycle counter and program register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r <= DIO_IDLE;
      disp_cnt_r <= '0;
      qual_d_r <= '0;
      prog_r <= PROG_RST;
    end else begin
      state_r <= state_nxt;
      disp_cnt_r <= disp_cnt_nxt;
      qual_d_r <= qual_r;
      prog_r <= prog_nxt;
    end
  end

  wire alarm_st_w;
  assign alarm_st_w = (state_nxt == DIO_ALARM) || (state_nxt == DIO_HALT);

  // registered outputs
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      io.alarm <= 1'b0;
      io.eoc_b <= 1'b1;
      regulate_out <= 1'b0;
      warn_out <= 1'b0;
      dispensing_out <= 1'b0;
      prog_out <= PROG_RST;
    end else begin
      io.alarm <= alarm_st_w;
      warn_out <= alarm_st_w;
      regulate_out <= regulate_w;
      io.eoc_b <= ~disp_st_w;
      dispensing_out <= disp_st_w;
      // output copy of the program register, same next value
      prog_out <= prog_nxt;
    end
  end
endmodule : dio_device

// [verilog/dio_ctrl.sv]
`timescale 1ns/1ps
module dio_ctrl
  import dio_pkg::*;
#(
  parameter int unsigned TRIG_CYC = dio_pkg::TRIG_MIN_CYC,
  parameter int unsigned SLOW_CYC = dio_pkg::SLOW_MIN_CYC
) (
  input wire logic clk_in,               // system clock
  input wire logic rst_b_in,             // async reset, low
  dio_if.ctrl io,                        // discrete i/o port
  input wire logic trig_req_in,          // pulse: voltage trigger
  input wire logic contact_req_in,       // pulse: contact trigger
  input wire logic step_req_in,          // pulse: program step
  input wire logic estop_req_in,         // pulse: estop
  input wire logic clear_req_in,         // pulse: toggle clear
  output logic busy_out,                 // a pulse is running
  output logic alarm_out,                // device alarm seen
  output logic dispensing_out            // device dispensing seen
);
  import dio_pkg::*;

  localparam int NP = 5;
  localparam int unsigned LEN_ARR [NP] =
    '{TRIG_CYC, TRIG_CYC, SLOW_CYC, SLOW_CYC, SLOW_CYC};

  wire [NP-1:0] req_w;
  assign req_w = {clear_req_in, estop_req_in, step_req_in,
                  contact_req_in, trig_req_in};
  logic [NP-1:0] drv_r;
  wire [NP-1:0] busy_w;

  // one pulse stretcher per line, holding twice the minimum width
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_p
      logic [CNT_W-1:0] cnt_r;
      assign busy_w[gi] = cnt_r != '0;
      always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          cnt_r <= '0;
          drv_r[gi] <= 1'b0;
        end else if (cnt_r != '0) begin
          cnt_r <= cnt_r - CNT_W'(1);
          if (cnt_r == CNT_W'(1)) begin
            drv_r[gi] <= 1'b0;
          end
        end else if (req_w[gi]) begin
          cnt_r <= CNT_W'(2 * LEN_ARR[gi]);
          drv_r[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  assign io.voltage_trigger = drv_r[0];
  assign io.contact_trigger = drv_r[1];
  assign io.prog_step = drv_r[2];
  assign io.estop = drv_r[3];
  assign io.alarm_clear = drv_r[4];

  // status capture
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_out <= 1'b0;
      alarm_out <= 1'b0;
      dispensing_out <= 1'b0;
    end else begin
      busy_out <= |busy_w;
      alarm_out <= io.alarm;
      dispensing_out <= ~io.eoc_b;
    end
  end
endmodule : dio_ctrl

// [test/dio_props.sv]
`timescale 1ns/1ps
module dio_props #(
  parameter int unsigned T = 4,
  parameter int unsigned S = 8,
  parameter int unsigned D = 20
) (
  input wire logic clk_in, // clock
  input wire logic rst_b_in, // reset
  input wire logic voltage_trigger, // start
  input wire logic contact_trigger, // start
  input wire logic prog_step, // step
  input wire logic estop, // halt
  input wire logic alarm_clear, // clear
  input wire logic alarm, // alarm
  input wire logic eoc_b // cycle low
);
  localparam int TL = T + 2;
  localparam int TH = T + 6;
  localparam int SL = S + 2;
  localparam int SH = S + 6;
  logic [7:0] low_r;
  // consecutive low cycles of end-of-cycle
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) low_r <= 8'h00;
    else low_r <= eoc_b ? 8'h00 : low_r + 8'h01;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // start seen as end-of-cycle falling after qualification
  sequence s_start;
    ##[TL:TH] !eoc_b;
  endsequence
  property p_vstart;
    $rose(voltage_trigger) && eoc_b && !alarm |-> s_start;
  endproperty
  a_vstart: assert property (p_vstart) else $error("no start");
  property p_cstart;
    $rose(contact_trigger) && eoc_b && !alarm |-> s_start;
  endproperty
  a_cstart: assert property (p_cstart) else $error("no start");
  property p_len;
    $rose(eoc_b) |-> low_r inside {[D - 1:D + 1]};
  endproperty
  a_len: assert property (p_len) else $error("cycle length");
  property p_block;
    alarm && $past(alarm) |-> eoc_b;
  endproperty
  a_block: assert property (p_block) else $error("cycle in alarm");
  property p_halt;
    $rose(estop) && !alarm |-> ##[SL:SH] alarm;
  endproperty
  a_halt: assert property (p_halt) else $error("no halt");
  property p_hold;
    alarm && estop |=> alarm;
  endproperty
  a_hold: assert property (p_hold) else $error("halt left");
  property p_clear;
    $rose(alarm_clear) && alarm && !estop |-> ##[SL:SH] !alarm;
  endproperty
  a_clear: assert property (p_clear) else $error("no clear");
  property p_stop;
    $rose(alarm) |=> eoc_b;
  endproperty
  a_stop: assert property (p_stop) else $error("cycle kept");
endmodule : dio_props

// [test/dispenser_io_control_tb.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module dispenser_io_control_tb;
  import dio_pkg::*;
  localparam int unsigned T = 4;
  localparam int unsigned S = 8;
  localparam int unsigned D = 20;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic touch = 1'b0;
  logic alm_req = 1'b0;
  logic [4:0] req = 5'h00;
  logic busy, c_alarm, c_disp, regulate, warn, d_disp;
  logic [3:0] prog;
  int error_cnt = 0;
  int cmp_count = 0;
  dio_if dio_if_inst ();
  dio_device #(.TRIG_CYC(T), .SLOW_CYC(S), .DISP_LEN(D)) dio_device_inst (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .io(dio_if_inst.device),
    .touch_in(touch), .alarm_req_in(alm_req), .regulate_out(regulate),
    .warn_out(warn), .dispensing_out(d_disp), .prog_out(prog));
  dio_ctrl #(.TRIG_CYC(T), .SLOW_CYC(S)) dio_ctrl_inst (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .io(dio_if_inst.ctrl),
    .trig_req_in(req[0]), .contact_req_in(req[1]), .step_req_in(req[2]),
    .estop_req_in(req[3]), .clear_req_in(req[4]), .busy_out(busy),
    .alarm_out(c_alarm), .dispensing_out(c_disp));
  dio_props #(.T(T), .S(S), .D(D)) dio_props_inst (
    .clk_in(clk_in), .rst_b_in(rst_b_in),
    .voltage_trigger(dio_if_inst.voltage_trigger),
    .contact_trigger(dio_if_inst.contact_trigger),
    .prog_step(dio_if_inst.prog_step), .estop(dio_if_inst.estop),
    .alarm_clear(dio_if_inst.alarm_clear), .alarm(dio_if_inst.alarm),
    .eoc_b(dio_if_inst.eoc_b));
  // clock, 10 ns period
  always #5 clk_in = ~clk_in;
  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task idle(input int n);
    repeat (n) @(negedge clk_in);
  endtask : idle
  // one request pulse, wait for the line to go quiet, then n cycles
  task send(input int k, input int n);
    int i;
    req[k] = 1'b1;
    idle(1);
    req[k] = 1'b0;
    // busy is registered, so it shows the pulse one cycle after it starts
    idle(1);
    for (i = 0; i < 100 && busy !== 1'b0; i++) idle(1);
    if (i == 100) begin
      error_cnt++;
      complete_run();
    end
    idle(n);
  endtask : send
  // general alarm event pulse
  task raise;
    alm_req = 1'b1;
    idle(1);
    alm_req = 1'b0;
    idle(6);
  endtask : raise
  // main sequence
  initial begin
    idle(2);
    rst_b_in = 1'b1;
    idle(2);
    `CHK(regulate, 1'b1)
    `CHK(prog, 4'h0)
    `CHK(dio_if_inst.eoc_b, 1'b1)
    $display("test reset done");
    send(0, 4);
    `CHK(d_disp, 1'b1)
    `CHK(dio_if_inst.eoc_b, 1'b0)
    `CHK(c_disp, 1'b1)
    send(0, 20);
    `CHK(d_disp, 1'b0)
    send(1, 4);
    `CHK(d_disp, 1'b1)
    idle(20);
    `CHK(dio_if_inst.eoc_b, 1'b1)
    $display("test trigger done");
    for (int i = 1; i <= 16; i++) begin
      send(2, 6);
      `CHK(prog, 4'(i))
    end
    $display("test program done");
    send(3, 4);
    `CHK(c_alarm, 1'b1)
    `CHK(regulate, 1'b0)
    `CHK(warn, 1'b1)
    send(0, 8);
    `CHK(d_disp, 1'b0)
    `CHK(c_alarm, 1'b1)
    send(4, 16);
    `CHK(c_alarm, 1'b0)
    `CHK(regulate, 1'b1)
    `CHK(warn, 1'b0)
    $display("test halt done");
    raise();
    idle(30);
    `CHK(c_alarm, 1'b1)
    `CHK(warn, 1'b1)
    send(0, 8);
    `CHK(d_disp, 1'b0)
    send(4, 16);
    `CHK(c_alarm, 1'b0)
    raise();
    `CHK(c_alarm, 1'b1)
    touch = 1'b1;
    idle(1);
    touch = 1'b0;
    idle(6);
    `CHK(c_alarm, 1'b0)
    $display("test alarm done");
    complete_run();
  end
endmodule : dispenser_io_control_tb
